// File: common/apco_pkg.sv
package apco_pkg;

  // ==========================================
  // register offsets
  localparam logic [7:0] APCO_OFS_X      = 8'h71;
  localparam logic [7:0] APCO_OFS_Y      = 8'h72;
  localparam logic [7:0] APCO_OFS_Z      = 8'h73;
  localparam logic [7:0] APCO_OFS_PWRCFG = 8'h7C;
  localparam logic [7:0] APCO_OFS_SENEN  = 8'h7D;
  localparam logic [7:0] APCO_OFS_CMD    = 8'h7E;

  // ==========================================
  // reset values
  localparam logic [7:0] APCO_RST_OFFSET = 8'h00;
  localparam logic [7:0] APCO_RST_PWRCFG = 8'h03;
  localparam logic [7:0] APCO_RST_SENEN  = 8'h00;
  localparam logic [7:0] APCO_CMD_READ   = 8'h00;

  // ==========================================
  // field positions
  localparam int APCO_BIT_APS = 0;
  localparam int APCO_BIT_FSW = 1;
  localparam int APCO_BIT_AUX = 0;
  localparam int APCO_BIT_ACC = 2;
  localparam logic [7:0] APCO_PWRCFG_MASK = 8'h03;
  localparam logic [7:0] APCO_SENEN_MASK  = 8'h05;

  // ==========================================
  // command codes
  localparam logic [7:0] APCO_CMD_NVM_PROG   = 8'hA0;
  localparam logic [7:0] APCO_CMD_QUEUE_FLSH = 8'hB0;
  localparam logic [7:0] APCO_CMD_SOFTRESET  = 8'hB6;

  // ==========================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } apco_req_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } apco_offs_t;

  typedef struct packed {
    logic       nvm_prog;
    logic       queue_flush;
    logic       soft_reset;
  } apco_cmd_t;

endpackage

// File: hw/apco_regs.sv
// What this block does
// - x offset register, reset zero, nvm-backed
// - y offset register, reset zero, nvm-backed
// - z offset register, reset zero, nvm-backed
// - offset added only when apply bit set
// - power config resets 0x03, bits 0/1
// - power save off keeps fast clock
// - power save on: slow clock when idle
// - self-wakeup off blocks queue reads in save
// - self-wakeup on allows reads after interrupt
// - sensor enable resets zero, bit 2 accel
// - sensor enable bit 0 auxiliary sensor
// - command register writes act, reads zero
// - 0xA0 copies backed registers into nvm
// - 0xB0 flushes queue, config kept
// - 0xB6 resets all user configuration
`timescale 1ns/100ps
module apco_regs
  import apco_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 rstn_in,
  // register access
  input  wire apco_pkg::apco_req_t  req_in,
  output logic [7:0]                rdata_out,
  // nvm load and status
  input  wire logic                 nvm_load_in,
  input  wire apco_pkg::apco_offs_t nvm_offs_in,
  // system state
  input  wire logic                 offset_apply_in,
  input  wire logic                 meas_busy_in,
  input  wire logic                 irq_seen_in,
  // outputs
  output apco_pkg::apco_offs_t      offs_applied_out,
  output apco_pkg::apco_offs_t      nvm_offs_out,
  output apco_pkg::apco_cmd_t       cmd_out,
  output logic                      fast_clk_en_out,
  output logic                      queue_rd_allow_out,
  output logic                      acc_en_out,
  output logic                      aux_en_out
);
  import apco_pkg::*;

  // ==========================================
  // state
  typedef struct packed {
    apco_offs_t offs;
    logic [7:0] pwrcfg;
    logic [7:0] senen;
    apco_cmd_t  cmd;
    logic [7:0] rdata;
    logic       woken;
  } apco_state_t;

  apco_state_t st_r;
  apco_state_t st_nxt;

  localparam apco_state_t APCO_ST_RST = '{
    offs:   '{x: APCO_RST_OFFSET, y: APCO_RST_OFFSET, z: APCO_RST_OFFSET},
    pwrcfg: APCO_RST_PWRCFG,
    senen:  APCO_RST_SENEN,
    cmd:    '{nvm_prog: 1'b0, queue_flush: 1'b0, soft_reset: 1'b0},
    rdata:  8'h00,
    woken:  1'b0
  };

  // ==========================================
  // next state
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.cmd = '{nvm_prog: 1'b0, queue_flush: 1'b0, soft_reset: 1'b0};
    if (st_r.cmd.soft_reset)
    begin
      st_nxt = APCO_ST_RST;
    end
    else
    begin
      if (nvm_load_in)
      begin
        st_nxt.offs = nvm_offs_in;
      end
      if (req_in.wr)
      begin
        if (req_in.addr == APCO_OFS_X)
        begin
          st_nxt.offs.x = req_in.wdata;
        end
        else if (req_in.addr == APCO_OFS_Y)
        begin
          st_nxt.offs.y = req_in.wdata;
        end
        else if (req_in.addr == APCO_OFS_Z)
        begin
          st_nxt.offs.z = req_in.wdata;
        end
        else if (req_in.addr == APCO_OFS_PWRCFG)
        begin
          st_nxt.pwrcfg = req_in.wdata & APCO_PWRCFG_MASK;
        end
        else if (req_in.addr == APCO_OFS_SENEN)
        begin
          st_nxt.senen = req_in.wdata & APCO_SENEN_MASK;
        end
        else if (req_in.addr == APCO_OFS_CMD)
        begin
          case (req_in.wdata)
            APCO_CMD_NVM_PROG:   st_nxt.cmd.nvm_prog = 1'b1;
            APCO_CMD_QUEUE_FLSH: st_nxt.cmd.queue_flush = 1'b1;
            APCO_CMD_SOFTRESET:  st_nxt.cmd.soft_reset = 1'b1;
            default:             st_nxt.cmd = st_nxt.cmd;
          endcase
        end
      end
      if (irq_seen_in)
      begin
        st_nxt.woken = 1'b1;
      end
      else if (meas_busy_in)
      begin
        st_nxt.woken = 1'b0;
      end
      // read data
      if (req_in.rd)
      begin
        if (req_in.addr == APCO_OFS_X)
        begin
          st_nxt.rdata = st_r.offs.x;
        end
        else if (req_in.addr == APCO_OFS_Y)
        begin
          st_nxt.rdata = st_r.offs.y;
        end
        else if (req_in.addr == APCO_OFS_Z)
        begin
          st_nxt.rdata = st_r.offs.z;
        end
        else if (req_in.addr == APCO_OFS_PWRCFG)
        begin
          st_nxt.rdata = st_r.pwrcfg;
        end
        else if (req_in.addr == APCO_OFS_SENEN)
        begin
          st_nxt.rdata = st_r.senen;
        end
        else
        begin
          st_nxt.rdata = APCO_CMD_READ;
        end
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r <= APCO_ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  logic aps_on;
  assign aps_on    = st_r.pwrcfg[APCO_BIT_APS];
  assign rdata_out = st_r.rdata;
  assign nvm_offs_out = st_r.offs;
  assign cmd_out      = st_r.cmd;

  assign offs_applied_out = offset_apply_in ? st_r.offs : '0;

  assign fast_clk_en_out = !aps_on || meas_busy_in;

  assign queue_rd_allow_out = !aps_on ||
                              (st_r.pwrcfg[APCO_BIT_FSW] && st_r.woken);

  assign acc_en_out = st_r.senen[APCO_BIT_ACC];
  assign aux_en_out = st_r.senen[APCO_BIT_AUX];

endmodule

// File: bench/apco_regs_asserts.sv
`timescale 1ns/100ps
// ==========
// register checks
module apco_regs_asserts
(
  input wire logic                core_clk_in,
  input wire logic                rstn_in,
  input wire apco_pkg::apco_req_t req_in,
  input wire logic                meas_busy_in,
  input wire logic                irq_seen_in,
  input wire apco_pkg::apco_cmd_t cmd_out,
  input wire logic                fast_clk_en_out,
  input wire logic                queue_rd_allow_out,
  input wire logic                acc_en_out,
  input wire logic                aux_en_out
);
  import apco_pkg::*;
  wire       w = req_in.wr;
  wire [7:0] a = req_in.addr;
  wire [7:0] d = req_in.wdata;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_cmd(c); w && a == 8'h7E && d == c; endsequence
  sequence s_cfg(v); w && a == 8'h7C && d[1:0] == v; endsequence
  prog_pulse_a:
    assert property (s_cmd(8'hA0) |=> cmd_out == 3'h4 ##1 cmd_out == 3'h0) else $error("nvm");
  flush_pulse_a:
    assert property (s_cmd(8'hB0) |=> cmd_out == 3'h2) else $error("flush");
  reset_pulse_a:
    assert property (s_cmd(8'hB6) |=> cmd_out == 3'h1 ##2 (!acc_en_out && !aux_en_out))
      else $error("soft reset");
  unknown_cmd_a:
    assert property (w && a == 8'h7E && !(d inside {8'hA0, 8'hB0, 8'hB6}) |=> cmd_out == 3'h0)
      else $error("unknown cmd");
  fast_clk_a:
    assert property (s_cfg(2'h0) |=> fast_clk_en_out) else $error("fast clk");
  slow_clk_a:
    assert property (s_cfg(2'h1) ##1 !meas_busy_in |-> !fast_clk_en_out) else $error("slow clk");
  read_block_a:
    assert property (s_cfg(2'h1) |=> !queue_rd_allow_out) else $error("read block");
  wake_read_a:
    assert property (s_cfg(2'h3) ##1 irq_seen_in |=> queue_rd_allow_out) else $error("wake");
  sensor_en_a:
    assert property (w && a == 8'h7D |=> acc_en_out == $past(d[2]) && aux_en_out == $past(d[0]))
      else $error("sensor enable");
endmodule
bind apco_regs apco_regs_asserts u_chk (.*);

// File: bench/apco_host.sv
`timescale 1ns/100ps
// ==========
// processor side
module apco_host
(
  input  wire logic          clk_in,
  input  wire logic [7:0]    rdata_in,
  output apco_pkg::apco_req_t req_out
);
  import apco_pkg::*;
  initial req_out = '0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in) req_out <= '{1'b1, 1'b0, a, d};
    @(posedge clk_in) req_out <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_in) req_out <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in) req_out <= '0;
    #1 q = rdata_in;
  endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
// ==========
// bench top
module testbench;
  import apco_pkg::*;
  logic       core_clk_in, rstn_in, nvm_load_in, offset_apply_in, meas_busy_in, irq_seen_in;
  logic       fast_clk_en_out, queue_rd_allow_out, acc_en_out, aux_en_out;
  logic [7:0] rdata_out, q;
  apco_req_t  req_in;
  apco_offs_t nvm_offs_in, offs_applied_out, nvm_offs_out;
  apco_cmd_t  cmd_out;
  int         fail_count, check_count;
  apco_host h (.clk_in(core_clk_in), .rdata_in(rdata_out), .req_out(req_in));
  apco_regs dut (.*);
  task chk(input logic [23:0] g, e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task rchk(input logic [7:0] a, e);
    h.rd(a, q);
    chk(q, e);
  endtask
  task give_verdict;
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task t_reset;
    rchk(8'h71, 8'h00);
    rchk(8'h72, 8'h00);
    rchk(8'h73, 8'h00);
    rchk(8'h7C, 8'h03);
    rchk(8'h7D, 8'h00);
    rchk(8'h70, 8'h00);
  endtask
  task t_offs;
    h.wr(8'h71, 8'h5A);
    h.wr(8'h72, 8'hA5);
    h.wr(8'h73, 8'h3C);
    rchk(8'h71, 8'h5A);
    rchk(8'h72, 8'hA5);
    rchk(8'h73, 8'h3C);
    chk(offs_applied_out, 24'h0);
    @(posedge core_clk_in) offset_apply_in <= 1'b1;
    #1 chk(offs_applied_out, 24'h5AA53C);
    @(posedge core_clk_in) nvm_load_in <= 1'b1;
    @(posedge core_clk_in) nvm_load_in <= 1'b0;
    #1 chk(nvm_offs_out, 24'h112233);
  endtask
  task t_pwr;
    h.wr(8'h7C, 8'hFC);
    rchk(8'h7C, 8'h00);
    chk({fast_clk_en_out, queue_rd_allow_out}, 2'h3);
    h.wr(8'h7C, 8'h01);
    #1 chk({fast_clk_en_out, queue_rd_allow_out}, 2'h0);
    @(posedge core_clk_in) meas_busy_in <= 1'b1;
    #1 chk(fast_clk_en_out, 1'b1);
    h.wr(8'h7C, 8'h03);
    meas_busy_in <= 1'b0;
    irq_seen_in <= 1'b1;
    @(posedge core_clk_in) irq_seen_in <= 1'b0;
    #1 chk(queue_rd_allow_out, 1'b1);
    h.wr(8'h7D, 8'hFF);
    rchk(8'h7D, 8'h05);
    h.wr(8'h7D, 8'h01);
    #1 chk({acc_en_out, aux_en_out}, 2'h1);
    h.wr(8'h7D, 8'h04);
  endtask
  task t_cmd;
    h.wr(8'h7E, 8'hA0);
    #1 chk(cmd_out, 3'h4);
    h.wr(8'h7E, 8'hB0);
    #1 chk(cmd_out, 3'h2);
    h.wr(8'h7E, 8'h5A);
    #1 chk(cmd_out, 3'h0);
    rchk(8'h7E, 8'h00);
    h.wr(8'h7E, 8'hB6);
    #1 chk(cmd_out, 3'h1);
    rchk(8'h7D, 8'h00);
    rchk(8'h71, 8'h00);
    rchk(8'h7C, 8'h03);
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    #50us;
    fail_count++;
    give_verdict;
  end
  initial
  begin
    {rstn_in, nvm_load_in, offset_apply_in, meas_busy_in, irq_seen_in} = '0;
    nvm_offs_in = 24'h112233;
    repeat (10) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    t_reset;
    t_offs;
    t_pwr;
    t_cmd;
    give_verdict;
  end
endmodule
